// *** verilog/pdcg_defs.vh ***
// Constants for the clock generator control logic
`ifndef PDCG_DEFS_VH
`define PDCG_DEFS_VH

`define PDCG_VCO_LO      2'h0
`define PDCG_VCO_MID     2'h1
`define PDCG_VCO_RSVD    2'h2
`define PDCG_VCO_HI      2'h3
`define PDCG_UNLOCK_DIV  6'h02
`define PDCG_IRC_HALF    4'h5
`define PDCG_SETTLE_CYC  16'h0040
`define PDCG_FAM_A       1'b0
`define PDCG_FAM_B       1'b1

`endif

// *** verilog/pdcg_clk_div.v ***
// Programmable toggle divider: output toggles every half_cnt+1 input enables
`timescale 1ns/1ps
`default_nettype none
module pdcg_clk_div #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_rst,
    input  wire         i_ce,
    // Divider control
    input  wire         i_en,
    input  wire [W-1:0] i_half_cnt,
    input  wire         i_bypass,
    // Output
    output reg          o_clk
);
    reg [W-1:0] cnt_q;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= {W{1'b0}};
            o_clk <= 1'b0;
        end else if (i_ce) begin
            if (i_bypass) begin
                // Bypass copies i_en onto o_clk one cycle later; enables on adjacent cycles merge into one pulse
                cnt_q <= {W{1'b0}};
                o_clk <= i_en;
            end else if (i_en) begin
                if (cnt_q >= i_half_cnt) begin
                    cnt_q <= {W{1'b0}};
                    o_clk <= ~o_clk;
                end else begin
                    cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // pdcg_clk_div
`default_nettype wire

// *** verilog/pdcg_top.v ***
// Clock generator control: reference, VCO model, post divider, bus clock
// The VCO is modelled as ticks of i_clk: each reference edge releases
// 2*(mult+1) VCO ticks in variant A, (mult+1) in variant B, so frequency
// ratios match the formulas while the analog loop stays outside.
`timescale 1ns/1ps
`default_nettype none
`include "pdcg_defs.vh"
module pdcg_top #(
    parameter MW      = 6,
    parameter RW      = 6,
    parameter PW      = 5,
    parameter FAMILY  = 1'b0,
    parameter SETTLE  = 16
) (
    // Clock, reset, enable
    input  wire          i_clk,
    input  wire          i_rst,
    input  wire          i_ce,
    // Oscillator pin
    input  wire          i_osc,
    // Configuration
    input  wire [1:0]    i_vco_gain_range,
    input  wire [1:0]    i_ref_filter_range,
    input  wire [MW-1:0] i_feedback_multiplier_value,
    input  wire [RW-1:0] i_reference_divider_value,
    input  wire [PW-1:0] i_post_divider_value,
    input  wire          i_pll_clock_select,
    input  wire          i_external_osc_enable,
    input  wire          i_pll_enable,
    // Status and clocks
    output reg           o_lock,
    output reg           o_ref_clk,
    output reg           o_pll_clk,
    output reg           o_bus_clk,
    output reg  [1:0]    o_filter_cfg,
    output reg           o_engaged_external_mode,
    output reg           o_engaged_internal_mode
);
    localparam ST_OFF    = 3'b001;
    localparam ST_SETTLE = 3'b010;
    localparam ST_LOCKED = 3'b100;

    // Three-stage pin synchroniser; edge counted when stages two and three agree
    reg        osc_s1_q, osc_s2_q, osc_s3_q, osc_lvl_q;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            osc_s1_q  <= 1'b0;
            osc_s2_q  <= 1'b0;
            osc_s3_q  <= 1'b0;
            osc_lvl_q <= 1'b0;
        end else if (i_ce) begin
            osc_s1_q <= i_osc;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            if (osc_s2_q == osc_s3_q)
                osc_lvl_q <= osc_s3_q;
        end
    end
    wire osc_rise = (osc_s2_q == osc_s3_q) & osc_s3_q & ~osc_lvl_q;

    // Internal 1 MHz reference: 10 MHz clock toggled every 5 cycles
    reg [3:0] irc_cnt_q;
    reg       irc_q;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irc_cnt_q <= 4'h0;
            irc_q     <= 1'b0;
        end else if (i_ce) begin
            if (irc_cnt_q == `PDCG_IRC_HALF - 4'h1) begin
                irc_cnt_q <= 4'h0;
                irc_q     <= ~irc_q;
            end else begin
                irc_cnt_q <= irc_cnt_q + 4'h1;
            end
        end
    end
    wire irc_rise = (irc_cnt_q == `PDCG_IRC_HALF - 4'h1) & ~irc_q;

    // Reference divider: one ref pulse per (reference_divider_value+1) oscillator edges; variant B internal mode takes each internal reference rise undivided
    reg [RW-1:0] rdiv_q;
    reg          ref_tick_q;
    wire use_irc = (FAMILY == `PDCG_FAM_B) & ~i_external_osc_enable;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdiv_q     <= {RW{1'b0}};
            ref_tick_q <= 1'b0;
        end else if (i_ce) begin
            ref_tick_q <= 1'b0;
            if (use_irc) begin
                rdiv_q     <= {RW{1'b0}};
                ref_tick_q <= irc_rise;
            end else if (osc_rise) begin
                if (rdiv_q >= i_reference_divider_value) begin
                    rdiv_q     <= {RW{1'b0}};
                    ref_tick_q <= 1'b1;
                end else begin
                    rdiv_q <= rdiv_q + {{(RW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // VCO tick generator: a burst of vco ticks per reference tick
    reg [MW+1:0] burst_q;
    reg          vco_tick_q;
    wire [MW+1:0] mult1 = {2'b00, i_feedback_multiplier_value}
                        + {{(MW+1){1'b0}}, 1'b1};
    wire [MW+1:0] burst_len = (FAMILY == `PDCG_FAM_A) ?
                              {mult1[MW:0], 1'b0} : mult1;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            burst_q    <= {(MW+2){1'b0}};
            vco_tick_q <= 1'b0;
        end else if (i_ce) begin
            if (ref_tick_q & i_pll_enable)
                burst_q <= burst_len;
            else if (burst_q != {(MW+2){1'b0}})
                burst_q <= burst_q - {{(MW+1){1'b0}}, 1'b1};
            vco_tick_q <= (burst_q != {(MW+2){1'b0}});
        end
    end

    // Lock tracking; a change of gain, multiplier, reference or post divider drops lock and restarts settle
    reg [2:0]    st_q;
    reg [15:0]   settle_q;
    reg [MW+RW+PW+1:0] cfg_q;
    wire [MW+RW+PW+1:0] cfg_now = {i_vco_gain_range,
        i_feedback_multiplier_value, i_reference_divider_value,
        i_post_divider_value};
    wire cfg_chg   = (cfg_now != cfg_q);
    wire gain_bad  = (i_vco_gain_range == `PDCG_VCO_RSVD);
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q     <= ST_OFF;
            settle_q <= 16'h0000;
            cfg_q    <= {(MW+RW+PW+2){1'b0}};
            o_lock   <= 1'b0;
        end else if (i_ce) begin
            cfg_q <= cfg_now;
            case (st_q)
                ST_OFF: begin
                    o_lock   <= 1'b0;
                    settle_q <= 16'h0000;
                    if (i_pll_enable & ~gain_bad)
                        st_q <= ST_SETTLE;
                end
                ST_SETTLE: begin
                    if (~i_pll_enable | gain_bad | cfg_chg) begin
                        st_q     <= i_pll_enable & ~gain_bad ?
                                    ST_SETTLE : ST_OFF;
                        settle_q <= 16'h0000;
                    end else if (ref_tick_q) begin
                        if (settle_q == SETTLE[15:0] - 16'h0001) begin
                            st_q   <= ST_LOCKED;
                            o_lock <= 1'b1;
                        end else begin
                            settle_q <= settle_q + 16'h0001;
                        end
                    end
                end
                ST_LOCKED: begin
                    if (~i_pll_enable | gain_bad | cfg_chg) begin
                        o_lock   <= 1'b0;
                        settle_q <= 16'h0000;
                        st_q     <= ST_OFF;
                    end
                end
                default: begin
                    st_q   <= ST_OFF;
                    o_lock <= 1'b0;
                end
            endcase
        end
    end

    // Post divider half-period selection per variant
    reg [PW:0] post_half;
    reg        post_byp;
    always @* begin
        post_half = {(PW+1){1'b0}};
        post_byp  = 1'b0;
        if (FAMILY == `PDCG_FAM_A) begin
            if (i_post_divider_value == {PW{1'b0}})
                post_byp = 1'b1;
            else
                post_half = {1'b0, i_post_divider_value}
                          - {{PW{1'b0}}, 1'b1};
        end else if (o_lock) begin
            // Pre-counter pulses are forwarded one per enable
            post_byp = 1'b1;
        end else begin
            post_half = `PDCG_UNLOCK_DIV - 6'h01;
        end
    end

    // Variant B locked needs odd ratios as well, which a toggle divider
    // cannot give: a pre-counter passes one pulse per post+1 VCO ticks.
    // Limitation: a divide-by-one setting shows one edge per burst, since
    // VCO ticks within a burst fall on adjacent clock cycles.
    reg  [PW-1:0] pre_q;
    wire          odd_mode = (FAMILY == `PDCG_FAM_B) & o_lock;
    wire          pre_hit  = vco_tick_q & (pre_q >= i_post_divider_value);
    wire          post_en  = odd_mode ? pre_hit : vco_tick_q;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_q <= {PW{1'b0}};
        end else if (i_ce & vco_tick_q) begin
            if (pre_hit)
                pre_q <= {PW{1'b0}};
            else
                pre_q <= pre_q + {{(PW-1){1'b0}}, 1'b1};
        end
    end

    wire pll_raw;
    pdcg_clk_div #(.W(PW+1)) u_post (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_en       (post_en),
        .i_half_cnt (post_half),
        .i_bypass   (post_byp),
        .o_clk      (pll_raw)
    );

    // Bus clock: half the PLL output when selected, else oscillator level
    reg pll_d_q;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pll_d_q   <= 1'b0;
            o_pll_clk <= 1'b0;
            o_bus_clk <= 1'b0;
            o_ref_clk <= 1'b0;
            o_filter_cfg            <= 2'h0;
            o_engaged_external_mode <= 1'b0;
            o_engaged_internal_mode <= 1'b0;
        end else if (i_ce) begin
            pll_d_q   <= pll_raw;
            o_pll_clk <= pll_raw;
            if (i_pll_clock_select) begin
                if (pll_raw & ~pll_d_q)
                    o_bus_clk <= ~o_bus_clk;
            end else begin
                o_bus_clk <= osc_lvl_q;
            end
            if (ref_tick_q)
                o_ref_clk <= ~o_ref_clk;
            o_filter_cfg <= i_ref_filter_range;
            o_engaged_external_mode <= (FAMILY == `PDCG_FAM_B) &
                i_pll_clock_select & i_external_osc_enable;
            o_engaged_internal_mode <= (FAMILY == `PDCG_FAM_B) &
                i_pll_clock_select & ~i_external_osc_enable;
        end
    end
endmodule // pdcg_top
`default_nettype wire

// *** tb/pdcg_osc_model.sv ***
// External oscillator model feeding the reference pin
`timescale 1ns/1ps
`default_nettype none
module pdcg_osc_model #(
    parameter HALF = 437
) (
    // Control and pin
    input  wire logic i_run,
    output var  logic o_osc
);
    initial o_osc = 1'b0;
    // Parked low when disabled, so internal mode cannot lean on it
    always #(HALF) o_osc = i_run ? ~o_osc : 1'b0;
endmodule // pdcg_osc_model
`default_nettype wire

// *** tb/pdcg_checker.sv ***
// Concurrent checks on the clock generator control ports
`timescale 1ns/1ps
`default_nettype none
module pdcg_checker #(
    parameter MW     = 6,
    parameter RW     = 6,
    parameter PW     = 5,
    parameter FAMILY = 1'b0,
    parameter SETTLE = 16
) (
    // Watched ports
    input wire logic i_clk, i_rst, i_ce, i_pll_enable, i_pll_clock_select,
    input wire logic i_external_osc_enable, o_lock, o_pll_clk,
    input wire logic o_engaged_external_mode, o_engaged_internal_mode,
    input wire logic [1:0]    i_vco_gain_range, i_ref_filter_range,
    input wire logic [1:0]    o_filter_cfg,
    input wire logic [MW-1:0] i_feedback_multiplier_value,
    input wire logic [RW-1:0] i_reference_divider_value,
    input wire logic [PW-1:0] i_post_divider_value
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic [MW+RW+PW+1:0] cfg = {i_vco_gain_range,
        i_feedback_multiplier_value, i_reference_divider_value,
        i_post_divider_value};
    wire logic run = i_pll_enable && i_pll_clock_select && i_ce;
    // Cycles since settling last had to restart
    reg [15:0] calm_q;
    always @(posedge i_clk or posedge i_rst)
        if (i_rst) calm_q <= 16'h0;
        else if ($changed(cfg) || !i_pll_enable) calm_q <= 16'h0;
        else if (calm_q != 16'hffff) calm_q <= calm_q + 16'h1;

    chk_reset_clear: assert property ($fell(i_rst) |-> !o_lock && !o_pll_clk)
        else $error("lock or clock set after reset");
    chk_rsvd_nolock: assert property ((i_vco_gain_range == 2'h2)[*3] |-> !o_lock)
        else $error("lock with reserved gain code");
    chk_cfg_unlock: assert property ($changed(cfg) && i_ce |-> ##[1:2] !o_lock)
        else $error("lock kept over a setting change");
    chk_en_unlock: assert property ((!i_pll_enable && i_ce)[*2] |-> !o_lock)
        else $error("lock while loop disabled");
    chk_lock_hold: assert property (o_lock && $stable(cfg) && i_pll_enable && $past(i_ce) && i_vco_gain_range != 2'h2 |=> o_lock)
        else $error("lock dropped without cause");
    chk_lock_settle: assert property ($rose(o_lock) |-> calm_q >= SETTLE)
        else $error("lock rose before settling");
    chk_filter_copy: assert property (($stable(i_ref_filter_range) && i_ce)[*3] |-> o_filter_cfg == i_ref_filter_range)
        else $error("filter range not applied");
    chk_mode_ext: assert property (((FAMILY == 1) && i_external_osc_enable && run)[*3] |-> o_engaged_external_mode && !o_engaged_internal_mode)
        else $error("external mode not shown");
    chk_mode_int: assert property (((FAMILY == 1) && !i_external_osc_enable && run)[*3] |-> o_engaged_internal_mode && !o_engaged_external_mode)
        else $error("internal mode not shown");
    cov_lock: cover property ($rose(o_lock));
    cov_rsvd: cover property ((i_vco_gain_range == 2'h2)[*3]);
    cov_int: cover property ($rose(o_engaged_internal_mode));
endmodule // pdcg_checker
bind pdcg_top pdcg_checker #(.MW(MW), .RW(RW), .PW(PW), .FAMILY(FAMILY),
    .SETTLE(SETTLE)) u_chk (.*);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the clock generator control
`timescale 1ns/1ps
`default_nettype none
module testbench;
    reg        clk, rst, ce, en, sel, ext, f;
    reg  [1:0] gain, filt;
    reg  [5:0] mul, rdv;
    reg  [4:0] pst;
    reg  [3:0] s_q = 4'h0;
    reg  [7:0] gt  = 8'hb4;
    wire       osc;
    wire [1:0] lk, rf, pl, bu, em, im;
    wire [3:0] fc;
    wire [3:0] s = {osc, bu[f], pl[f], rf[f]};
    integer    fail_count = 0, tests_run = 0, n[0:3] = '{0, 0, 0, 0};
    integer    a[0:3], i, b, k, m, r, p, c, pn, pd, t0;

    pdcg_osc_model #(.HALF(437)) u_osc (.i_run(ext), .o_osc(osc));
    genvar g;
    for (g = 0; g < 2; g = g + 1) begin : gd
        pdcg_top #(.FAMILY(g), .SETTLE(2)) u_dut (
            .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_osc(osc),
            .i_vco_gain_range(gain), .i_ref_filter_range(filt),
            .i_feedback_multiplier_value(mul),
            .i_reference_divider_value(rdv),
            .i_post_divider_value(pst), .i_pll_clock_select(sel),
            .i_external_osc_enable(ext), .i_pll_enable(en),
            .o_lock(lk[g]), .o_ref_clk(rf[g]), .o_pll_clk(pl[g]),
            .o_bus_clk(bu[g]), .o_filter_cfg(fc[2*g+:2]),
            .o_engaged_external_mode(em[g]),
            .o_engaged_internal_mode(im[g]));
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Edges counted mid-cycle, after register outputs have settled
    always @(negedge clk) begin
        for (int j = 0; j < 4; j++) if (s[j] && !s_q[j]) n[j]++;
        s_q = s;
    end

    task cmpb(input logic [3:0] act, input logic [3:0] exp);
        tests_run++;
        if (act !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, act, exp);
        end
    endtask
    // One edge of slack: the window is not phase aligned to the divider
    task cmpn(input integer act, input integer num, input integer den);
        tests_run++;
        if (act * den > num + den || act * den < num - den) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, act, num / den);
        end
    endtask
    task summarize;
        if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Edges over four reference periods, variant chosen by f
    task meas;
        // Window is eight reference ticks: VCO ticks 2*(m+1) or (m+1) each
        pd = f ? (gain == 2'h2 ? 4 : p + 1) : 2 * p;
        pn = (f ? 8 : 16) * (m + 1);
        k = n[0];
        wait (n[0] == k + 1);
        a = n;
        t0 = $time / 100;
        wait (n[0] == k + 5);
        if (!ext) cmpn($time / 100 - t0, 8 * 10, 1);
        cmpn(n[1] - a[1], pn, pd);
        cmpn(n[2] - a[2], sel ? pn : ext * 8 * (r + 1), sel ? 2 * pd : 1);
        if (ext) cmpn(n[3] - a[3], 8 * (r + 1), 1);
    endtask

    initial begin
        #6000000;
        fail_count++;
        summarize;
    end

    initial begin
        {ce, en, sel, ext, f, gain, filt, mul, rdv, pst} = 0;
        rst = 1'b1;
        void'($urandom(32'hcda11bea));
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        ce = 1'b1;
        en = 1'b1;
        for (i = 0; i < 7; i++) begin
            m = $urandom % 4;
            r = 1 + $urandom % 3;
            p = 1 + $urandom % 3;
            @(posedge clk);
            #1 {mul, rdv, pst} = {m[5:0], r[5:0], p[4:0]};
            gain = gt[2*(i%4)+:2];
            filt = 2'($urandom);
            sel = 1'($urandom);
            ext = i != 1 && i != 4;
            repeat (3) @(posedge clk);
            for (b = !ext; b < 2; b++) begin
                f = b[0];
                c = 0;
                while (lk[f] !== 1'b1 && c < 3000) begin
                    @(posedge clk);
                    c++;
                end
                cmpb(lk[f], gain != 2'h2);
                cmpb(fc[2*f+:2], filt);
                meas;
            end
        end
        @(posedge clk);
        #1 mul = mul ^ 6'h1;
        repeat (3) @(posedge clk);
        #1 cmpb(lk, 2'h0);
        en = 1'b0;
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        cmpb({lk, pl}, 4'h0);
        #1 rst = 1'b0;
        en = 1'b1;
        ce = 1'b1;
        repeat (5) @(posedge clk);
        summarize;
    end
endmodule // testbench
`default_nettype wire
